// ---- tb/tcv_console_monitor.sv ----
/* Checker for the console top: sync, scroll, read and irq timing.
   Assumes it is bound to tcv_console and sees only its ports. */
`timescale 1ns/1ps
module tcv_console_monitor (
  input wire logic       clk,
  input wire logic       srst,
  input wire logic       vga_hsync_n,
  input wire logic [3:0] vga_red,
  input wire logic [3:0] vga_green,
  input wire logic [3:0] vga_blue,
  input wire logic       cpu_scroll,
  input wire logic [4:0] line_offset,
  input wire logic       cpu_kb_rd,
  input wire logic       kb_line_ready,
  input wire logic       cpu_kb_rvalid,
  input wire logic       kb_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // ==========================================================
  // Line counters
  logic [9:0] low_cnt;
  logic [9:0] per_cnt;
  logic       h_q;
  logic       seen;
  // The first line after reset is partial, so it is not measured.
  always_ff @(posedge clk) begin
    h_q     <= vga_hsync_n;
    low_cnt <= vga_hsync_n ? 10'h0 : low_cnt + 10'h1;
    per_cnt <= (h_q && !vga_hsync_n) ? 10'h1 : per_cnt + 10'h1;
    seen    <= srst ? 1'b0 : (seen | (h_q && !vga_hsync_n));
  end
  // ==========================================================
  // Properties
  hsync_width_a: assert property ($rose(vga_hsync_n) |-> low_cnt == 10'd96)
    else $error("hsync width wrong");
  line_period_a: assert property ($fell(vga_hsync_n) && seen |-> per_cnt == 10'd800)
    else $error("line period wrong");
  sync_blank_a: assert property (!vga_hsync_n |-> vga_red == 4'h0)
    else $error("colour during sync");
  hsync_dark_a: assert property (!vga_hsync_n |-> (vga_green | vga_blue) == 4'h0)
    else $error("green or blue during sync");
  irq_width_a: assert property ($rose(kb_irq) |=> kb_irq ##1 !kb_irq)
    else $error("irq not two cycles");
  irq_end_a: assert property (kb_irq && $past(kb_irq) |=> !kb_irq)
    else $error("irq too long");
  scroll_step_a: assert property (cpu_scroll |=> line_offset == $past(line_offset) + 5'h1)
    else $error("offset step wrong");
  offset_hold_a: assert property (!cpu_scroll |=> $stable(line_offset))
    else $error("offset moved");
  read_answer_a: assert property (cpu_kb_rd && kb_line_ready |=> cpu_kb_rvalid)
    else $error("read not answered");
  read_quiet_a: assert property (!(cpu_kb_rd && kb_line_ready) |=> !cpu_kb_rvalid)
    else $error("stray read valid");
endmodule
bind tcv_console tcv_console_monitor tcv_console_monitor_inst (
  .clk(clk), .srst(srst), .vga_hsync_n(vga_hsync_n), .vga_red(vga_red),
  .vga_green(vga_green), .vga_blue(vga_blue),
  .cpu_scroll(cpu_scroll), .line_offset(line_offset), .cpu_kb_rd(cpu_kb_rd),
  .kb_line_ready(kb_line_ready), .cpu_kb_rvalid(cpu_kb_rvalid), .kb_irq(kb_irq)
);

// ---- tb/tcv_console_tb_top.sv ----
/* Bench for the console top: boot probe, typing, enter hand-over,
   clear, scroll and keyboard send. Assumes pull-ups on both pins. */
`timescale 1ns/1ps
module tcv_console_tb_top;
  logic        clk = 1'b0, srst = 1'b1, line_clr = 1'b0, cpu_we = 1'b0;
  logic        cpu_scroll = 1'b0, cpu_kb_ack = 1'b0, cpu_kb_rd = 1'b0;
  logic        kb_tx_start = 1'b0;
  logic [11:0] cpu_addr = 12'h0;
  logic [7:0]  cpu_wdata = 8'h0, kb_tx_byte = 8'h0, cpu_kb_rdata;
  logic [6:0]  cpu_kb_idx = 7'h0;
  logic [4:0]  line_offset;
  logic [3:0]  vga_red, vga_green, vga_blue;
  logic        vga_hsync_n, vga_vsync_n, kb_line_ready, cpu_kb_rvalid, kb_irq;
  logic        kb_absent, kb_tx_busy, ps2_clk_oe, ps2_dat_oe, kclk, kdat;
  int          fails = 0, total_checks = 0;
  always #50 clk = ~clk;
  tcv_console #(.PRESENT_CYC(200), .IDLE_CYC(2000)) tcv_console_inst (
    .clk, .srst, .line_clr, .vga_hsync_n, .vga_vsync_n, .vga_red, .vga_green,
    .vga_blue, .cpu_we, .cpu_addr, .cpu_wdata, .cpu_scroll, .line_offset,
    .cpu_kb_ack, .kb_line_ready, .cpu_kb_rd, .cpu_kb_idx, .cpu_kb_rdata,
    .cpu_kb_rvalid, .kb_irq, .kb_absent, .kb_tx_start, .kb_tx_byte, .kb_tx_busy,
    .ps2_clk_i(kclk & ~ps2_clk_oe), .ps2_dat_i(kdat & ~ps2_dat_oe), .ps2_clk_o(),
    .ps2_clk_oe, .ps2_dat_o(), .ps2_dat_oe);
  tcv_kbd_model tcv_kbd_model_inst (.kclk, .kdat, .hdat(kdat & ~ps2_dat_oe));
  // ==========================================================
  // Helpers
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic ack;
    cpu_kb_ack = 1'b1;
    cyc(1);
    cpu_kb_ack = 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [6:0] idx, input logic [7:0] exp);
    int n;
    n = 0;
    while (kb_line_ready !== 1'b1 && n < 50) begin
      cyc(1);
      n++;
    end
    cpu_kb_idx = idx;
    cpu_kb_rd = 1'b1;
    cyc(1);
    cpu_kb_rd = 1'b0;
    chk("read valid", 8'h1, {7'h0, cpu_kb_rvalid});
    chk("read data", exp, cpu_kb_rdata);
    cyc(1);
  endtask
  task automatic stop_test;
    $display("checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_boot;
    chk("irq", 8'h0, {7'h0, kb_irq});
    chk("offset", 8'h0, {3'h0, line_offset});
    cyc(5000);
    chk("absent", 8'h1, {7'h0, kb_absent});
    chk("vsync", 8'h1, {7'h0, vga_vsync_n});
    $display("boot done");
  endtask
  task automatic t_type;
    int n, w;
    n = 0;
    w = 0;
    tcv_kbd_model_inst.send(8'h16, 2'h0);
    tcv_kbd_model_inst.send(8'h1e, 2'h1);
    tcv_kbd_model_inst.send(8'h1e, 2'h2);
    tcv_kbd_model_inst.send(tcv_pkg::SC_BREAK, 2'h0);
    tcv_kbd_model_inst.send(8'h16, 2'h0);
    tcv_kbd_model_inst.send(8'h1e, 2'h0);
    fork
      tcv_kbd_model_inst.send(tcv_pkg::SC_ENTER, 2'h0);
      begin
        while (kb_irq !== 1'b1 && n < 300) begin
          cyc(1);
          n++;
        end
        while (kb_irq === 1'b1 && w < 9) begin
          cyc(1);
          w++;
        end
      end
    join
    chk("irq width", 8'h2, w[7:0]);
    ack;
    rd(7'd0, 8'h31);
    rd(7'd1, 8'h32);
    rd(7'd2, tcv_pkg::CH_SPACE);
    $display("typing done");
  endtask
  task automatic t_clr;
    line_clr = 1'b1;
    cyc(1);
    line_clr = 1'b0;
    ack;
    rd(7'd0, tcv_pkg::CH_SPACE);
    $display("clear done");
  endtask
  task automatic t_scroll;
    cpu_we = 1'b1;
    cpu_addr = {5'd29, 7'd0};
    cpu_wdata = 8'h41;
    cyc(1);
    cpu_we = 1'b0;
    cpu_scroll = 1'b1;
    cyc(2);
    cpu_scroll = 1'b0;
    chk("offset", 8'h2, {3'h0, line_offset});
    $display("scroll done");
  endtask
  task automatic t_send;
    logic [9:0] f;
    kb_tx_byte = 8'hed;
    kb_tx_start = 1'b1;
    cyc(1);
    kb_tx_start = 1'b0;
    chk("tx busy", 8'h1, {7'h0, kb_tx_busy});
    cyc(5);
    chk("clk inhibit", 8'h1, {7'h0, ps2_clk_oe});
    cyc(996);
    chk("start bit", 8'h1, {7'h0, ps2_dat_oe});
    tcv_kbd_model_inst.recv(f);
    chk("tx data", 8'hed, f[7:0]);
    chk("tx parity stop", 8'h3, {6'h0, f[9:8]});
    cyc(5);
    chk("tx done", 8'h0, {7'h0, kb_tx_busy});
    kb_tx_start = 1'b1;
    cyc(1);
    kb_tx_start = 1'b0;
    cyc(3100);
    chk("tx abort", 8'h0, {7'h0, kb_tx_busy});
    $display("send done");
  endtask
  initial begin
    cyc(8);
    srst = 1'b0;
    cyc(1);
    t_boot;
    t_type;
    t_clr;
    t_scroll;
    t_send;
    stop_test;
  end
  initial begin
    #1_500_000;
    fails++;
    stop_test;
  end
endmodule

// ---- tb/tcv_kbd_model.sv ----
/* Keyboard model: sends frames on open-drain clock and data lines.
   Assumes the bench ANDs its lines with the console's pull-downs. */
`timescale 1ns/1ps
module tcv_kbd_model (
  output logic kclk,
  output logic kdat,
  input  wire logic hdat
);
  initial begin
    kclk = 1'b1;
    kdat = 1'b1;
  end
  // frame layout, parity
  // Bit 0 of bad spoils the parity, bit 1 the stop bit.
  task automatic send(input logic [7:0] b, input logic [1:0] bad);
    logic [10:0] f;
    f = {~bad[1], ~^b ^ bad[0], b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      kdat = f[i];
      #200;
      kclk = 1'b0;
      #400;
      kclk = 1'b1;
      #200;
    end
    kdat = 1'b1;
  endtask
  // host-to-device receive
  // Each bit is read just before the next fall, after the host has settled it.
  task automatic recv(output logic [9:0] f);
    for (int i = 0; i < 11; i++) begin
      kclk = 1'b0;
      #400;
      kclk = 1'b1;
      #350;
      if (i < 10) begin
        f[i] = hdat;
      end
      #50;
    end
  endtask
endmodule

// ---- verilog/tcv_console.sv ----
/*
  Text console top: raster timing, scrolled character store, keyboard
  input line and keyboard event handling toward the processor.
  Assumes one 10 MHz clock; pins resolved and pulled up outside.
*/
// Behaviour
// - Produce sync pulses and pixel colour for a 640x480 raster.
// - One character code per memory word, one word per screen cell.
// - Each pixel looks up its cell code and a glyph bit from font ROM.
// - Fixed-width cells; column comes straight from horizontal position.
// - Refresh continuously at 60Hz; scan-out never stalls. At 10 MHz with PIX_DIV 1 the 800x525 frame repeats at about 23.8Hz.
// - Any stored code renders safely without upsetting timing.
// - A new line moves rows up; newest at bottom, oldest leaves.
// - Character store is dual-port: display reads, processor writes.
// - Rows addressed via line offset; one increment scrolls in one cycle.
// - Separate keyboard input line, written by keyboard, read by both.
// - Asynchronous clear sets every input-line character to 20 hex.
// - Keyboard bits collected by a shift register on the link clock.
// - Letters, digits and address punctuation translated and stored.
// - Enter hands the typed line to the processor.
// - At power-up probe for a keyboard; flag absence to the processor.
// - Send any byte to the keyboard by host-to-device procedure.
// - Bad start, stop or parity discards the frame.
// - A valid character is written at one character per cycle.
// - Keyboard and processor never drive input-line addressing together.
// - Enter raises the interrupt for exactly two clock cycles.
`timescale 1ns/1ps
module tcv_console #(
  parameter int PRESENT_CYC = tcv_pkg::PRESENT_CYC,
  parameter int IDLE_CYC    = tcv_pkg::IDLE_CYC,
  parameter int PIX_DIV     = 1
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        line_clr,
  output logic             vga_hsync_n,
  output logic             vga_vsync_n,
  output logic [3:0]       vga_red,
  output logic [3:0]       vga_green,
  output logic [3:0]       vga_blue,
  input  wire logic        cpu_we,
  input  wire logic [11:0] cpu_addr,
  input  wire logic [7:0]  cpu_wdata,
  input  wire logic        cpu_scroll,
  output logic [4:0]       line_offset,
  input  wire logic        cpu_kb_ack,
  output logic             kb_line_ready,
  input  wire logic        cpu_kb_rd,
  input  wire logic [6:0]  cpu_kb_idx,
  output logic [7:0]       cpu_kb_rdata,
  output logic             cpu_kb_rvalid,
  output logic             kb_irq,
  output logic             kb_absent,
  input  wire logic        kb_tx_start,
  input  wire logic [7:0]  kb_tx_byte,
  output logic             kb_tx_busy,
  input  wire logic        ps2_clk_i,
  input  wire logic        ps2_dat_i,
  output logic             ps2_clk_o,
  output logic             ps2_clk_oe,
  output logic             ps2_dat_o,
  output logic             ps2_dat_oe
);
  localparam int PW = $clog2(PRESENT_CYC + 1);
  // Hex glyph ROM, 3x5 dots, top row in the high bits.
  localparam logic [14:0] HEX_FONT [16] = '{
    15'h7b6f, 15'h2c97, 15'h73e7, 15'h73cf, 15'h5bc9, 15'h79cf, 15'h79ef, 15'h7249,
    15'h7bef, 15'h7bcf, 15'h2bed, 15'h6bae, 15'h3923, 15'h6b6e, 15'h79e7, 15'h79a4};

  // ==========================================================
  // Glyph and scan code functions
  // any code renders: each except 20 hex (shown blank) shows as its two hex digits, so none can fail.
  function automatic logic glyph_px(input logic [7:0] code, input logic [2:0] x,
                                    input logic [3:0] y);
    logic [3:0] nib;
    logic [3:0] fr;
    logic [3:0] fc;
    nib = x[2] ? code[3:0] : code[7:4];
    fr = (y - 4'h3) >> 1;
    fc = {2'h0, x[1:0]};
    if (code == tcv_pkg::CH_SPACE || y < 4'h3 || y > 4'hc || x[1:0] == 2'h3) begin
      return 1'b0;
    end
    return HEX_FONT[nib][4'he - (fr * 4'h3 + fc)];
  endfunction

  function automatic logic [7:0] xlate(input logic [7:0] sc, input logic ext);
    logic [7:0] c;
    c = 8'h00;
    if (ext) begin
      c = (sc == tcv_pkg::SC_SLASH) ? 8'h2f : 8'h00;
    end else begin
      unique case (sc)
        8'h1c: c = 8'h41;
        8'h32: c = 8'h42;
        8'h21: c = 8'h43;
        8'h23: c = 8'h44;
        8'h24: c = 8'h45;
        8'h2b: c = 8'h46;
        8'h34: c = 8'h47;
        8'h33: c = 8'h48;
        8'h43: c = 8'h49;
        8'h3b: c = 8'h4a;
        8'h42: c = 8'h4b;
        8'h4b: c = 8'h4c;
        8'h3a: c = 8'h4d;
        8'h31: c = 8'h4e;
        8'h44: c = 8'h4f;
        8'h4d: c = 8'h50;
        8'h15: c = 8'h51;
        8'h2d: c = 8'h52;
        8'h1b: c = 8'h53;
        8'h2c: c = 8'h54;
        8'h3c: c = 8'h55;
        8'h2a: c = 8'h56;
        8'h1d: c = 8'h57;
        8'h22: c = 8'h58;
        8'h35: c = 8'h59;
        8'h1a: c = 8'h5a;
        8'h45: c = 8'h30;
        8'h16: c = 8'h31;
        8'h1e: c = 8'h32;
        8'h26: c = 8'h33;
        8'h25: c = 8'h34;
        8'h2e: c = 8'h35;
        8'h36: c = 8'h36;
        8'h3d: c = 8'h37;
        8'h3e: c = 8'h38;
        8'h46: c = 8'h39;
        8'h29: c = 8'h20;
        8'h49: c = 8'h2e;
        8'h4a: c = 8'h2f;
        8'h4e: c = 8'h2d;
        8'h4c: c = 8'h3a;
        default: c = 8'h00;
      endcase
    end
    return c;
  endfunction

  // ==========================================================
  // Raster counters and pixel pipeline
  logic [7:0] div, next_div;
  logic pix_en, vis0, hs0, vs0;
  logic [9:0] h_cnt, v_cnt, next_h, next_v;
  logic [6:0] col0;
  logic [4:0] row0;
  logic [11:0] rd_addr;
  logic [2:0] p1_x, next_p1_x;
  logic [3:0] p1_y, next_p1_y;
  logic p1_vis, p1_hs, p1_vs, p1_kb, next_p1_vis, next_p1_hs, next_p1_vs, next_p1_kb;
  logic [7:0] p1_kbch, next_p1_kbch, ram_q, code;
  logic px, next_hs_n, next_vs_n;
  logic [3:0] next_r, next_g, next_b;
  logic [7:0] kbline [tcv_pkg::COLS];

  always_comb begin
    pix_en = (div == 8'(PIX_DIV - 1));
    next_div = pix_en ? 8'h00 : div + 8'h01;
    next_h = h_cnt;
    next_v = v_cnt;
    if (pix_en) begin
      if (h_cnt == 10'(tcv_pkg::H_TOT - 1)) begin
        next_h = '0;
        next_v = (v_cnt == 10'(tcv_pkg::V_TOT - 1)) ? 10'h000 : v_cnt + 10'h001;
      end else begin
        next_h = h_cnt + 10'h001;
      end
    end
    vis0 = (h_cnt < 10'(tcv_pkg::H_VIS)) && (v_cnt < 10'(tcv_pkg::V_VIS));
    hs0 = (h_cnt >= 10'(tcv_pkg::H_VIS + tcv_pkg::H_FP)) &&
          (h_cnt < 10'(tcv_pkg::H_VIS + tcv_pkg::H_FP + tcv_pkg::H_SYNC));
    vs0 = (v_cnt >= 10'(tcv_pkg::V_VIS + tcv_pkg::V_FP)) &&
          (v_cnt < 10'(tcv_pkg::V_VIS + tcv_pkg::V_FP + tcv_pkg::V_SYNC));
    col0 = h_cnt[9:3];
    row0 = v_cnt[8:4];
    rd_addr = {row0 + line_offset, col0};
    next_p1_x = p1_x;
    next_p1_y = p1_y;
    next_p1_vis = p1_vis;
    next_p1_hs = p1_hs;
    next_p1_vs = p1_vs;
    next_p1_kb = p1_kb;
    next_p1_kbch = p1_kbch;
    if (pix_en) begin
      next_p1_x = h_cnt[2:0];
      next_p1_y = v_cnt[3:0];
      next_p1_vis = vis0;
      next_p1_hs = hs0;
      next_p1_vs = vs0;
      // input line shown on the last row
      next_p1_kb = (row0 == 5'(tcv_pkg::KB_ROW));
      next_p1_kbch = (col0 < 7'(tcv_pkg::COLS)) ? kbline[col0] : tcv_pkg::CH_SPACE;
    end
    code = p1_kb ? p1_kbch : ram_q;
    px = p1_vis && glyph_px(code, p1_x, p1_y);
    next_hs_n = pix_en ? ~p1_hs : vga_hsync_n;
    next_vs_n = pix_en ? ~p1_vs : vga_vsync_n;
    next_r = pix_en ? {4{px}} : vga_red;
    next_g = pix_en ? {4{px}} : vga_green;
    next_b = pix_en ? {4{px & ~p1_kb}} : vga_blue;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      div <= '0;
      h_cnt <= '0;
      v_cnt <= '0;
      p1_x <= '0;
      p1_y <= '0;
      {p1_vis, p1_hs, p1_vs, p1_kb} <= '0;
      p1_kbch <= tcv_pkg::CH_SPACE;
      {vga_hsync_n, vga_vsync_n} <= 2'h3;
      {vga_red, vga_green, vga_blue} <= '0;
    end else begin
      div <= next_div;
      h_cnt <= next_h;
      v_cnt <= next_v;
      p1_x <= next_p1_x;
      p1_y <= next_p1_y;
      {p1_vis, p1_hs, p1_vs, p1_kb} <= {next_p1_vis, next_p1_hs, next_p1_vs, next_p1_kb};
      p1_kbch <= next_p1_kbch;
      {vga_hsync_n, vga_vsync_n} <= {next_hs_n, next_vs_n};
      {vga_red, vga_green, vga_blue} <= {next_r, next_g, next_b};
    end
  end

  // ==========================================================
  // Scrolled character store
  // write port for processor, read port for scan-out
  logic [7:0] vram [1 << tcv_pkg::ADDR_W];
  always_ff @(posedge clk) begin
    if (cpu_we) begin
      vram[cpu_addr] <= cpu_wdata;
    end
    if (pix_en) begin
      ram_q <= vram[rd_addr];
    end
  end

  // one offset step moves every row up
  always_ff @(posedge clk) begin
    if (srst) begin
      line_offset <= '0;
    end else begin
      line_offset <= line_offset + {4'h0, cpu_scroll};
    end
  end

  // ==========================================================
  // Keyboard input line
  logic rx_valid, rx_error, link_start, kb_char, kb_bksp, kb_enter, kb_wr;
  logic brk, ext, next_brk, next_ext, prefix;
  logic [7:0] rx_byte, link_byte, ch, wr_ch;
  logic [6:0] cursor, next_cursor, wr_idx;

  always_comb begin
    prefix = (rx_byte == tcv_pkg::SC_BREAK) || (rx_byte == tcv_pkg::SC_EXT);
    ch = xlate(rx_byte, ext);
    kb_char = rx_valid && !brk && !prefix && (ch != 8'h00);
    kb_bksp = rx_valid && !brk && !ext && (rx_byte == tcv_pkg::SC_BKSP);
    kb_enter = rx_valid && !brk && (rx_byte == tcv_pkg::SC_ENTER);
    kb_wr = (kb_char && cursor < 7'(tcv_pkg::COLS)) || (kb_bksp && cursor != 7'h00);
    wr_idx = kb_bksp ? cursor - 7'h01 : cursor;
    wr_ch = kb_bksp ? tcv_pkg::CH_SPACE : ch;
    next_cursor = kb_wr ? (kb_bksp ? wr_idx : cursor + 7'h01) : cursor;
  end

  always_ff @(posedge clk or posedge line_clr) begin
    if (line_clr) begin
      kbline <= '{default: tcv_pkg::CH_SPACE};
      cursor <= '0;
    end else if (srst) begin
      kbline <= '{default: tcv_pkg::CH_SPACE};
      cursor <= '0;
    end else begin
      if (kb_wr) begin
        kbline[wr_idx] <= wr_ch;
      end
      cursor <= next_cursor;
    end
  end

  // ==========================================================
  // Keyboard control, hand-over and boot probe
  logic [1:0] irq_cnt, next_irq_cnt;
  logic pending, granted, grant_rd, next_pending, next_granted, next_irq, next_absent;
  logic next_rvalid;
  logic [7:0] next_rdata;
  logic [PW-1:0] pres_cnt, next_pres_cnt;
  tcv_pkg::tcv_boot_t boot, next_boot;

  always_comb begin
    next_brk = brk;
    next_ext = ext;
    if (rx_valid) begin
      next_brk = (rx_byte == tcv_pkg::SC_BREAK);
      next_ext = (rx_byte == tcv_pkg::SC_EXT) || (ext && rx_byte == tcv_pkg::SC_BREAK);
    end
    next_pending = pending;
    next_granted = granted;
    next_irq_cnt = (irq_cnt != 2'h0) ? irq_cnt - 2'h1 : 2'h0;
    if (kb_enter) begin
      next_irq_cnt = tcv_pkg::IRQ_CYC;
      next_pending = 1'b1;
      next_granted = 1'b0;
    end else if (cpu_kb_ack && pending) begin
      next_pending = 1'b0;
      next_granted = 1'b1;
    end
    if (kb_wr) begin
      next_granted = 1'b0;
    end
    next_irq = (next_irq_cnt != 2'h0);
    // keyboard write locks out processor access
    kb_line_ready = granted && !kb_wr;
    grant_rd = cpu_kb_rd && kb_line_ready && (cpu_kb_idx < 7'(tcv_pkg::COLS));
    next_rvalid = grant_rd;
    next_rdata = grant_rd ? kbline[cpu_kb_idx] : cpu_kb_rdata;
    // probe for a keyboard after reset
    next_boot = boot;
    next_pres_cnt = pres_cnt;
    next_absent = kb_absent;
    link_start = 1'b0;
    link_byte = kb_tx_byte;
    unique case (boot)
      tcv_pkg::BT_SEND: begin
        link_byte = tcv_pkg::CMD_RST;
        link_start = !kb_tx_busy;
        next_boot = kb_tx_busy ? boot : tcv_pkg::BT_WAIT;
        next_pres_cnt = '0;
      end
      tcv_pkg::BT_WAIT: begin
        next_pres_cnt = pres_cnt + 1'b1;
        if (rx_valid || rx_error) begin
          next_boot = tcv_pkg::BT_DONE;
        end else if (pres_cnt == PW'(PRESENT_CYC - 1)) begin
          next_boot = tcv_pkg::BT_DONE;
          next_absent = 1'b1;
        end
      end
      tcv_pkg::BT_DONE: begin
        link_start = kb_tx_start && !kb_tx_busy;
      end
      default: begin
        next_boot = tcv_pkg::BT_SEND;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      {brk, ext, pending, granted, kb_irq, kb_absent, cpu_kb_rvalid} <= '0;
      irq_cnt <= '0;
      cpu_kb_rdata <= '0;
      pres_cnt <= '0;
      boot <= tcv_pkg::BT_SEND;
    end else begin
      {brk, ext, pending, granted} <= {next_brk, next_ext, next_pending, next_granted};
      {kb_irq, kb_absent, cpu_kb_rvalid} <= {next_irq, next_absent, next_rvalid};
      irq_cnt <= next_irq_cnt;
      cpu_kb_rdata <= next_rdata;
      pres_cnt <= next_pres_cnt;
      boot <= next_boot;
    end
  end

  tcv_ps2_link #(
    .IDLE_CYC (IDLE_CYC)
  ) u_link (
    .clk        (clk),
    .srst       (srst),
    .ps2_clk_i  (ps2_clk_i),
    .ps2_dat_i  (ps2_dat_i),
    .ps2_clk_o  (ps2_clk_o),
    .ps2_clk_oe (ps2_clk_oe),
    .ps2_dat_o  (ps2_dat_o),
    .ps2_dat_oe (ps2_dat_oe),
    .tx_start   (link_start),
    .tx_byte    (link_byte),
    .tx_busy    (kb_tx_busy),
    .rx_valid   (rx_valid),
    .rx_byte    (rx_byte),
    .rx_error   (rx_error)
  );
endmodule

// ---- verilog/tcv_pkg.sv ----
/*
  Shared constants for the text console: raster timing, character cell
  geometry, keyboard scan codes, link timing and state encodings.
  Assumes a single 10 MHz system clock.
*/
package tcv_pkg;
  // ==========================================================
  // Raster timing in pixel ticks
  localparam int H_VIS  = 640;
  localparam int H_FP   = 16;
  localparam int H_SYNC = 96;
  localparam int H_TOT  = 800;
  localparam int V_VIS  = 480;
  localparam int V_FP   = 10;
  localparam int V_SYNC = 2;
  localparam int V_TOT  = 525;
  // ==========================================================
  // Character cells
  localparam int COLS      = 80;
  localparam int KB_ROW    = 29;
  localparam int ADDR_W    = 12;
  localparam logic [7:0] CH_SPACE = 8'h20;
  // ==========================================================
  // Keyboard link timing
  localparam int CLK_HZ      = 10_000_000;
  localparam int INHIBIT_US  = 100;
  localparam int INHIBIT_CYC = (INHIBIT_US * (CLK_HZ / 1_000_000));
  localparam int IDLE_US     = 2000;
  localparam int IDLE_CYC    = IDLE_US * (CLK_HZ / 1_000_000);
  localparam int PRESENT_MS  = 2000;
  localparam int PRESENT_CYC = PRESENT_MS * (CLK_HZ / 1000);
  localparam logic [1:0] IRQ_CYC = 2'h2;
  // ==========================================================
  // Scan codes and commands
  localparam logic [7:0] SC_BREAK = 8'hf0;
  localparam logic [7:0] SC_EXT   = 8'he0;
  localparam logic [7:0] SC_ENTER = 8'h5a;
  localparam logic [7:0] SC_BKSP  = 8'h66;
  localparam logic [7:0] SC_SLASH = 8'h4a;
  localparam logic [7:0] CMD_RST  = 8'hff;
  // ==========================================================
  // State encodings
  typedef enum logic [3:0] {
    TX_IDLE  = 4'b0001,
    TX_INHIB = 4'b0010,
    TX_SHIFT = 4'b0100,
    TX_ACK   = 4'b1000
  } tcv_tx_t;
  typedef enum logic [2:0] {
    BT_SEND = 3'b001,
    BT_WAIT = 3'b010,
    BT_DONE = 3'b100
  } tcv_boot_t;
endpackage

// ---- verilog/tcv_ps2_link.sv ----
/*
  Keyboard serial link: frame receiver with start, stop and parity checks,
  and host-to-keyboard byte transmitter.
  Assumes open-drain pins resolved outside; link clock is sampled by clk.
*/
`timescale 1ns/1ps
module tcv_ps2_link #(
  parameter int INHIBIT_CYC = tcv_pkg::INHIBIT_CYC,
  parameter int IDLE_CYC    = tcv_pkg::IDLE_CYC
) (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       ps2_clk_i,
  input  wire logic       ps2_dat_i,
  output logic            ps2_clk_o,
  output logic            ps2_clk_oe,
  output logic            ps2_dat_o,
  output logic            ps2_dat_oe,
  input  wire logic       tx_start,
  input  wire logic [7:0] tx_byte,
  output logic            tx_busy,
  output logic            rx_valid,
  output logic [7:0]      rx_byte,
  output logic            rx_error
);
  localparam int TMAX = (IDLE_CYC > INHIBIT_CYC) ? IDLE_CYC : INHIBIT_CYC;
  localparam int TW   = $clog2(TMAX + 1);

  logic cs1, cs2, cs3, ds1, ds2;
  logic fall, timeout;
  logic [10:0] rx_sh, next_rx_sh, frame;
  logic [3:0] rx_cnt, next_rx_cnt, tx_cnt, next_tx_cnt;
  logic [TW-1:0] tmr, next_tmr;
  logic [9:0] tx_sh, next_tx_sh;
  logic tx_bit, next_tx_bit;
  logic next_rx_valid, next_rx_error;
  logic [7:0] next_rx_byte;
  tcv_pkg::tcv_tx_t state, next_state;

  // ==========================================================
  // Pin synchronisers
  always_ff @(posedge clk) begin
    cs1 <= ps2_clk_i;
    cs2 <= cs1;
    cs3 <= cs2;
    ds1 <= ps2_dat_i;
    ds2 <= ds1;
  end

  // ==========================================================
  // Receive and transmit sequencing
  always_comb begin
    fall = cs3 & ~cs2;
    timeout = (tmr == TW'(IDLE_CYC));
    frame = {ds2, rx_sh[10:1]};
    next_rx_sh = rx_sh;
    next_rx_cnt = rx_cnt;
    next_tx_cnt = tx_cnt;
    next_tx_sh = tx_sh;
    next_tx_bit = tx_bit;
    next_state = state;
    next_rx_valid = 1'b0;
    next_rx_error = 1'b0;
    next_rx_byte = rx_byte;
    next_tmr = fall ? '0 : (timeout ? tmr : tmr + 1'b1);
    unique case (state)
      tcv_pkg::TX_IDLE: begin
        if (timeout) begin
          next_rx_cnt = '0;
        end
        if (fall) begin
          next_rx_sh = frame;
          next_rx_cnt = rx_cnt + 1'b1;
          if (rx_cnt == 4'ha) begin
            next_rx_cnt = '0;
            if (!frame[0] && frame[10] && (^frame[9:1])) begin
              next_rx_valid = 1'b1;
              next_rx_byte = frame[8:1];
            end else begin
              next_rx_error = 1'b1;
            end
          end
        end
        if (tx_start) begin
          next_state = tcv_pkg::TX_INHIB;
          next_tmr = '0;
          next_rx_cnt = '0;
          next_tx_sh = {1'b1, ~(^tx_byte), tx_byte};
        end
      end
      tcv_pkg::TX_INHIB: begin
        // Our own clock pull-down looks like an edge, so ignore it here.
        next_tmr = tmr + 1'b1;
        if (tmr == TW'(INHIBIT_CYC - 1)) begin
          next_state = tcv_pkg::TX_SHIFT;
          next_tx_bit = 1'b0;
          next_tx_cnt = '0;
          next_tmr = '0;
        end
      end
      tcv_pkg::TX_SHIFT: begin
        if (fall) begin
          next_tx_bit = tx_sh[0];
          next_tx_sh = {1'b1, tx_sh[9:1]};
          next_tx_cnt = tx_cnt + 1'b1;
          if (tx_cnt == 4'h9) begin
            next_state = tcv_pkg::TX_ACK;
          end
        end else if (timeout) begin
          next_state = tcv_pkg::TX_IDLE;
          next_tx_bit = 1'b1;
        end
      end
      tcv_pkg::TX_ACK: begin
        if (fall || timeout) begin
          next_state = tcv_pkg::TX_IDLE;
          next_tx_bit = 1'b1;
        end
      end
      default: begin
        next_state = tcv_pkg::TX_IDLE;
        next_tx_bit = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= tcv_pkg::TX_IDLE;
      rx_sh <= '0;
      rx_cnt <= '0;
      tx_cnt <= '0;
      tx_sh <= '1;
      tx_bit <= 1'b1;
      tmr <= '0;
      rx_valid <= 1'b0;
      rx_error <= 1'b0;
      rx_byte <= '0;
    end else begin
      state <= next_state;
      rx_sh <= next_rx_sh;
      rx_cnt <= next_rx_cnt;
      tx_cnt <= next_tx_cnt;
      tx_sh <= next_tx_sh;
      tx_bit <= next_tx_bit;
      tmr <= next_tmr;
      rx_valid <= next_rx_valid;
      rx_error <= next_rx_error;
      rx_byte <= next_rx_byte;
    end
  end

  assign ps2_clk_o = 1'b0;
  assign ps2_dat_o = 1'b0;
  assign ps2_clk_oe = (state == tcv_pkg::TX_INHIB);
  assign ps2_dat_oe = ~tx_bit;
  assign tx_busy = (state != tcv_pkg::TX_IDLE);
endmodule
